/* shared/spicf_pkg.sv */
package spicf_pkg;
	// register byte addresses
	localparam logic [4:0] ADDR_CTRL1 = 5'h00;
	localparam logic [4:0] ADDR_CTRL2 = 5'h04;
	localparam logic [4:0] ADDR_BAUD = 5'h08;
	localparam logic [4:0] ADDR_STATUS = 5'h0C;
	localparam logic [4:0] ADDR_DATA = 5'h10;
	// control one fields
	localparam int C1_LOW_FIRST = 0;
	localparam int C1_SEL_OUT = 1;
	localparam int C1_PHASE = 2;
	localparam int C1_POL = 3;
	localparam int C1_MASTER = 4;
	localparam int C1_TX_MASK = 5;
	localparam int C1_ENABLE = 6;
	localparam int C1_RX_MASK = 7;
	// control two fields
	localparam int C2_SINGLE = 0;
	localparam int C2_SINGLE_OE = 3;
	localparam int C2_FAULT_EN = 4;
	// status fields
	localparam int ST_FAULT = 4;
	localparam int ST_TX_EMPTY = 5;
	localparam int ST_RX_FULL = 7;
	// reset values, edge count per byte and response codes
	localparam logic [7:0] CTRL1_RESET = 8'h00;
	localparam logic [7:0] CTRL2_RESET = 8'h00;
	localparam logic [7:0] BAUD_RESET = 8'h04;
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// shifter operations
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_LOAD = 3'h1;
	localparam logic [2:0] OP_LOAD_SHOW = 3'h2;
	localparam logic [2:0] OP_SHOW = 3'h3;
	localparam logic [2:0] OP_SAMPLE = 3'h4;
	localparam logic [2:0] OP_SHIFT = 3'h5;
	localparam logic [2:0] OP_SHIFT_DIRECT = 3'h6;
	// master sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LEAD = 4'b0010,
		ST_RUN = 4'b0100,
		ST_TRAIL = 4'b1000
	} spicf_state_t;
endpackage

/* shared/spicf_shift_if.sv */
`timescale 1ns/1ps
interface spicf_shift_if;
	logic [2:0] op;
	logic [7:0] load_data;
	logic serial_in;
	logic low_first;
	logic out_bit;
	logic [7:0] rx_data;
	modport core (output op, output load_data, output serial_in, output low_first,
		input out_bit, input rx_data);
	modport shifter (input op, input load_data, input serial_in, input low_first,
		output out_bit, output rx_data);
endinterface

/* hdl/spicf_shifter.sv */
`timescale 1ns/1ps
module spicf_shifter (
	input wire logic clk_in,
	input wire logic arst_n_in,
	spicf_shift_if.shifter sh
);
	logic [7:0] shift_reg;
	logic latch_reg;
	logic out_reg;
	logic [7:0] shifted;
	logic [7:0] shifted_direct;

	// direction of shift follows the bit order
	always_comb begin
		shifted = sh.low_first ? {latch_reg, shift_reg[7:1]} : {shift_reg[6:0], latch_reg};
		shifted_direct = sh.low_first ? {sh.serial_in, shift_reg[7:1]}
			: {shift_reg[6:0], sh.serial_in};
	end

	// shift register and sampled bit
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			shift_reg <= 8'h00;
			latch_reg <= 1'b0;
		end else begin
			case (sh.op)
				spicf_pkg::OP_LOAD, spicf_pkg::OP_LOAD_SHOW: shift_reg <= sh.load_data;
				spicf_pkg::OP_SAMPLE: latch_reg <= sh.serial_in;
				spicf_pkg::OP_SHIFT: shift_reg <= shifted;
				spicf_pkg::OP_SHIFT_DIRECT: shift_reg <= shifted_direct;
				default: shift_reg <= shift_reg;
			endcase
		end
	end

	// output bit register: the bit leaving the shifter next
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			out_reg <= 1'b0;
		end else begin
			case (sh.op)
				spicf_pkg::OP_LOAD_SHOW:
					out_reg <= sh.low_first ? sh.load_data[0] : sh.load_data[7];
				spicf_pkg::OP_SHOW: out_reg <= sh.low_first ? shift_reg[0] : shift_reg[7];
				spicf_pkg::OP_SHIFT: out_reg <= sh.low_first ? shift_reg[1] : shift_reg[6];
				default: out_reg <= out_reg;
			endcase
		end
	end

	assign sh.out_bit = out_reg;
	assign sh.rx_data = shift_reg;
endmodule

/* hdl/spicf_core.sv */
`timescale 1ns/1ps
// Operation
// - polarity bit inverts the serial clock path.
// - phase one: bit one at first edge, bit eight ends after sixteenth edge.
// - phase one: master select low half period before start, high after bit eight.
// - phase one: slave drives on select fall, first bit at first edge.
// - phase one: even edges sample, odd edges shift in and drive next bit.
// - phase zero: bit one starts at select, bit eight ends at last edge.
// - phase zero: master select low at first bit, high half period after.
// - phase zero: slave drives first bit on select fall, odd edges sample.
// - select output and fault enable in master drive select during transfers.
// - fault detection off while select output is enabled.
// - single-pin mode: master uses its out pin, slave its out pin.
// - single-pin direction bit gates driving; same pin feeds the shifter.
// - single-pin mode leaves clock and select roles unchanged.
// - fault in single-pin master moves data onto the slave pin.
// - one interrupt request from masked flags.
// - select is a fault input in master with fault enable, no select output.
// - fault sets flag, clears master, releases clock and data drivers outside single-pin mode.
// - fault flag clears after a read while set then control one write.
// - slave goes idle when select rises mid transfer.
// - master waits half a clock period after data write before clocking.
module spicf_core (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_out,
	input wire logic master_data_io_in,
	output logic master_data_io_out,
	output logic master_data_io_oe_out,
	input wire logic slave_data_io_in,
	output logic slave_data_io_out,
	output logic slave_data_io_oe_out,
	input wire logic select_n_in,
	output logic select_n_out,
	output logic select_n_oe_out,
	output logic irq_out
);
	spicf_shift_if sh ();
	spicf_shifter u_shifter (.clk_in(clk_in), .arst_n_in(arst_n_in), .sh(sh));

	logic [7:0] ctrl1_reg, ctrl2_reg, baud_reg, tx_buf_reg, rx_buf_reg;
	logic tx_empty_reg, rx_full_reg, fault_reg, fault_armed_reg, rx_armed_reg;
	logic bvalid_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	spicf_pkg::spicf_state_t state_reg, state_next;
	logic [7:0] div_cnt_reg;
	logic [4:0] edge_cnt_reg;
	logic sclk_lvl_reg, sel_n_reg, done_reg, slave_loaded_reg;
	logic [3:0] sync1_reg, sync2_reg;
	logic sclk_prev_reg;

	logic enable, master, pol, phase, low_first, sel_out, single, single_oe, fault_en;
	logic wr_fire, rd_fire, wr_ok, wr_ctrl1, wr_data, rd_status, rd_data;
	logic tick, fault_event, sclk_s, mosi_s, miso_s, sel_s, slave_edge, slave_active;
	logic [4:0] edge_num;
	logic [2:0] edge_action, op_next;

	assign enable = ctrl1_reg[spicf_pkg::C1_ENABLE];
	assign master = ctrl1_reg[spicf_pkg::C1_MASTER];
	assign pol = ctrl1_reg[spicf_pkg::C1_POL];
	assign phase = ctrl1_reg[spicf_pkg::C1_PHASE];
	assign low_first = ctrl1_reg[spicf_pkg::C1_LOW_FIRST];
	assign sel_out = ctrl1_reg[spicf_pkg::C1_SEL_OUT];
	assign single = ctrl2_reg[spicf_pkg::C2_SINGLE];
	assign single_oe = ctrl2_reg[spicf_pkg::C2_SINGLE_OE];
	assign fault_en = ctrl2_reg[spicf_pkg::C2_FAULT_EN];

	// pins come from another clock: two flops before any logic reads them
	logic [3:0] pins_raw;
	assign pins_raw = {select_n_in, slave_data_io_in, master_data_io_in, serial_clock_pin_in};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					sync1_reg[gi] <= 1'b1;
					sync2_reg[gi] <= 1'b1;
				end else begin
					sync1_reg[gi] <= pins_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate
	assign sclk_s = sync2_reg[0];
	assign mosi_s = sync2_reg[1];
	assign miso_s = sync2_reg[2];
	assign sel_s = sync2_reg[3];

	// axi4-lite handshakes: a write is taken only with address and data together
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign rd_fire = s_axi_arvalid && !rvalid_reg;
	assign s_axi_arready = rd_fire;
	assign wr_ok = wr_fire && s_axi_wstrb[0];
	assign wr_ctrl1 = wr_ok && s_axi_awaddr == spicf_pkg::ADDR_CTRL1;
	assign wr_data = wr_ok && s_axi_awaddr == spicf_pkg::ADDR_DATA;
	assign rd_status = rd_fire && s_axi_araddr == spicf_pkg::ADDR_STATUS;
	assign rd_data = rd_fire && s_axi_araddr == spicf_pkg::ADDR_DATA;

	// fault: select low while it is the fault input
	assign fault_event = enable && master && fault_en && !sel_out && !sel_s;

	// write response channel
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= spicf_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= (s_axi_awaddr == spicf_pkg::ADDR_STATUS || s_axi_awaddr > spicf_pkg::ADDR_DATA)
				? spicf_pkg::RESP_SLVERR : spicf_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// read channel, data from a register
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= spicf_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= spicf_pkg::RESP_OKAY;
			case (s_axi_araddr)
				spicf_pkg::ADDR_CTRL1: rdata_reg <= {24'h00_0000, ctrl1_reg};
				spicf_pkg::ADDR_CTRL2: rdata_reg <= {24'h00_0000, ctrl2_reg};
				spicf_pkg::ADDR_BAUD: rdata_reg <= {24'h00_0000, baud_reg};
				spicf_pkg::ADDR_STATUS: rdata_reg <= {24'h00_0000, rx_full_reg, 1'b0,
					tx_empty_reg, fault_reg, 4'h0};
				spicf_pkg::ADDR_DATA: rdata_reg <= {24'h00_0000, rx_buf_reg};
				default: begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= spicf_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// control registers; a fault drops master mode and wins over the write
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl1_reg <= spicf_pkg::CTRL1_RESET;
			ctrl2_reg <= spicf_pkg::CTRL2_RESET;
			baud_reg <= spicf_pkg::BAUD_RESET;
		end else begin
			if (wr_ctrl1) ctrl1_reg <= s_axi_wdata[7:0];
			if (fault_event) ctrl1_reg[spicf_pkg::C1_MASTER] <= 1'b0;
			if (wr_ok && s_axi_awaddr == spicf_pkg::ADDR_CTRL2) ctrl2_reg <= s_axi_wdata[7:0];
			if (wr_ok && s_axi_awaddr == spicf_pkg::ADDR_BAUD) begin
				baud_reg <= (s_axi_wdata[7:0] == 8'h00) ? 8'h01 : s_axi_wdata[7:0];
			end
		end
	end

	// fault flag: read while set arms, a later control one write clears; set wins
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			fault_reg <= 1'b0;
			fault_armed_reg <= 1'b0;
		end else if (fault_event) begin
			fault_reg <= 1'b1;
			fault_armed_reg <= 1'b0;
		end else begin
			if (wr_ctrl1 && fault_armed_reg) fault_reg <= 1'b0;
			if (wr_ctrl1) fault_armed_reg <= 1'b0;
			else if (rd_status && fault_reg) fault_armed_reg <= 1'b1;
		end
	end

	// buffers: receive full clears by status read then data read; a completion wins over the clear
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_buf_reg <= 8'h00;
			tx_empty_reg <= 1'b1;
			rx_buf_reg <= 8'h00;
			rx_full_reg <= 1'b0;
			rx_armed_reg <= 1'b0;
		end else begin
			if (wr_data) begin
				tx_buf_reg <= s_axi_wdata[7:0];
				tx_empty_reg <= 1'b0;
			end else if (op_next == spicf_pkg::OP_LOAD || op_next == spicf_pkg::OP_LOAD_SHOW) begin
				tx_empty_reg <= 1'b1;
			end
			if (done_reg) begin
				rx_full_reg <= 1'b1;
				rx_armed_reg <= 1'b0;
				if (!rx_full_reg) rx_buf_reg <= sh.rx_data; // overrun keeps the old byte
			end else if (rd_data && rx_armed_reg) begin
				rx_full_reg <= 1'b0;
				rx_armed_reg <= 1'b0;
			end else if (rd_status && rx_full_reg) begin
				rx_armed_reg <= 1'b1;
			end
		end
	end

	// master half-period divider; runs only during a transfer
	assign tick = state_reg != spicf_pkg::ST_IDLE && div_cnt_reg == baud_reg - 8'h01;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_cnt_reg <= 8'h00;
		end else if (state_reg == spicf_pkg::ST_IDLE || tick) begin
			div_cnt_reg <= 8'h00;
		end else begin
			div_cnt_reg <= div_cnt_reg + 8'h01;
		end
	end

	// edge action: phase zero samples odd edges, phase one samples even ones
	assign edge_num = edge_cnt_reg + 5'h01;
	always_comb begin
		if (!phase) begin
			edge_action = edge_num[0] ? spicf_pkg::OP_SAMPLE : spicf_pkg::OP_SHIFT;
		end else if (edge_num == 5'h01) begin
			edge_action = spicf_pkg::OP_SHOW;
		end else if (edge_num == spicf_pkg::EDGES_PER_BYTE) begin
			edge_action = spicf_pkg::OP_SHIFT_DIRECT;
		end else begin
			edge_action = edge_num[0] ? spicf_pkg::OP_SHIFT : spicf_pkg::OP_SAMPLE;
		end
	end

	// slave clock edges count only while selected
	assign slave_edge = sclk_s != sclk_prev_reg;
	assign slave_active = enable && !master && !sel_s;

	// master sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			spicf_pkg::ST_IDLE:
				if (enable && master && !tx_empty_reg && !fault_event) state_next = spicf_pkg::ST_LEAD;
			spicf_pkg::ST_LEAD:
				if (tick) state_next = spicf_pkg::ST_RUN;
			spicf_pkg::ST_RUN:
				if (tick && edge_num == spicf_pkg::EDGES_PER_BYTE) state_next = spicf_pkg::ST_TRAIL;
			spicf_pkg::ST_TRAIL:
				if (tick) state_next = spicf_pkg::ST_IDLE;
			default: state_next = spicf_pkg::ST_IDLE;
		endcase
		if (fault_event || !enable || !master) state_next = spicf_pkg::ST_IDLE;
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) state_reg <= spicf_pkg::ST_IDLE;
		else state_reg <= state_next;
	end

	// shifter operation for this cycle
	always_comb begin
		op_next = spicf_pkg::OP_NONE;
		if (master) begin
			if (state_reg == spicf_pkg::ST_IDLE && state_next == spicf_pkg::ST_LEAD) begin
				op_next = phase ? spicf_pkg::OP_LOAD : spicf_pkg::OP_LOAD_SHOW;
			end else if (state_reg == spicf_pkg::ST_RUN && tick) begin
				op_next = edge_action;
			end
		end else if (slave_active) begin
			if (!slave_loaded_reg) begin
				op_next = phase ? spicf_pkg::OP_LOAD : spicf_pkg::OP_LOAD_SHOW;
			end else if (slave_edge) begin
				op_next = edge_action;
			end
		end
	end
	assign sh.op = op_next;
	assign sh.load_data = tx_buf_reg;
	assign sh.low_first = low_first;
	// single pin: the driven pin also feeds the shifter
	assign sh.serial_in = (master ^ single) ? miso_s : mosi_s;

	// edge counter, clock level and completion pulse
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			edge_cnt_reg <= 5'h00;
			sclk_lvl_reg <= 1'b0;
			done_reg <= 1'b0;
			slave_loaded_reg <= 1'b0;
			sclk_prev_reg <= 1'b0;
		end else begin
			sclk_prev_reg <= sclk_s;
			done_reg <= 1'b0;
			if (master) begin
				slave_loaded_reg <= 1'b0;
				if (state_reg == spicf_pkg::ST_RUN && tick) begin
					sclk_lvl_reg <= !sclk_lvl_reg;
					edge_cnt_reg <= edge_num;
				end else if (state_reg == spicf_pkg::ST_TRAIL && tick) begin
					done_reg <= 1'b1;
					edge_cnt_reg <= 5'h00;
				end else if (state_reg == spicf_pkg::ST_IDLE) begin
					edge_cnt_reg <= 5'h00;
					sclk_lvl_reg <= 1'b0;
				end
			end else if (!slave_active) begin
				edge_cnt_reg <= 5'h00;
				slave_loaded_reg <= 1'b0;
				sclk_lvl_reg <= 1'b0;
			end else if (!slave_loaded_reg) begin
				slave_loaded_reg <= 1'b1;
			end else if (slave_edge) begin
				if (edge_num == spicf_pkg::EDGES_PER_BYTE) begin
					edge_cnt_reg <= 5'h00;
					done_reg <= 1'b1;
					slave_loaded_reg <= 1'b0; // reload, select may stay low
				end else begin
					edge_cnt_reg <= edge_num;
				end
			end
			// an abort must not leave the clock level or the count mid-byte
			if (state_next == spicf_pkg::ST_IDLE) begin
				sclk_lvl_reg <= 1'b0;
				if (master) edge_cnt_reg <= 5'h00;
			end
		end
	end

	// automatic select: low from lead-in through trail
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) sel_n_reg <= 1'b1;
		else sel_n_reg <= state_next == spicf_pkg::ST_IDLE;
	end

	// pin drivers; a fault leaves master mode so the master drivers drop
	assign serial_clock_pin_out = sclk_lvl_reg ^ pol;
	assign serial_clock_pin_oe_out = enable && master;
	assign master_data_io_out = sh.out_bit;
	assign master_data_io_oe_out = enable && master && (!single || single_oe);
	assign slave_data_io_out = sh.out_bit;
	assign slave_data_io_oe_out = slave_active && (single ? single_oe : !fault_reg);
	assign select_n_out = sel_n_reg;
	assign select_n_oe_out = enable && master && sel_out && fault_en;
	assign irq_out = (ctrl1_reg[spicf_pkg::C1_RX_MASK] && (rx_full_reg || fault_reg))
		|| (ctrl1_reg[spicf_pkg::C1_TX_MASK] && tx_empty_reg);

	// checks
	sclk_rest_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		state_reg == spicf_pkg::ST_IDLE |-> serial_clock_pin_out == pol)
		else $error("serial clock not at rest level");
	irq_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(fault_reg && ctrl1_reg[spicf_pkg::C1_RX_MASK]) |-> irq_out)
		else $error("masked fault did not raise irq");
	fault_take_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		fault_event |=> fault_reg && !master && !serial_clock_pin_oe_out && !master_data_io_oe_out)
		else $error("fault did not leave master mode");
	fault_off_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		sel_out |=> !$rose(fault_reg))
		else $error("fault seen with select output on");
	fault_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$fell(fault_reg) |-> $past(wr_ctrl1) && $past(fault_armed_reg))
		else $error("fault flag cleared without read then write");
	slave_idle_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(!master && sel_s) |=> edge_cnt_reg == 5'h00 && !done_reg)
		else $error("slave not idle while deselected");
	lead_wait_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(state_reg == spicf_pkg::ST_LEAD) |-> !sclk_lvl_reg throughout
			(state_reg == spicf_pkg::ST_LEAD) [*1])
		else $error("clock moved during lead-in");
	sel_low_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		state_reg == spicf_pkg::ST_RUN |-> !select_n_out)
		else $error("select high during clocking");
	single_pin_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		(single && master) |-> !slave_data_io_oe_out)
		else $error("unused data pin driven");
	edge_total_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(state_reg == spicf_pkg::ST_TRAIL) |-> edge_cnt_reg == spicf_pkg::EDGES_PER_BYTE)
		else $error("wrong edge count per byte");
	master_done_c: cover property (@(posedge clk_in) disable iff (!arst_n_in)
		master && done_reg);
	slave_done_c: cover property (@(posedge clk_in) disable iff (!arst_n_in)
		!master && done_reg);
	fault_c: cover property (@(posedge clk_in) disable iff (!arst_n_in) fault_event);
endmodule

/* verif/spicf_far_model.sv */
`timescale 1ns/1ps
// far-side slave, behavioural at event level so any baud setting is followed
module spicf_far_model (
	input wire logic sclk_in,
	input wire logic sel_n_in,
	input wire logic mosi_in,
	input wire logic phase_in,
	input wire logic low_first_in,
	input wire logic [7:0] tx_in,
	output logic miso_out,
	output logic [7:0] rx_out
);
	int cnt;
	// bit of the outgoing byte in wire order
	function automatic logic bit_at(input int i);
		return low_first_in ? tx_in[i] : tx_in[7 - i];
	endfunction
	// power-up state of the model
	initial begin
		cnt = 0;
		miso_out = 1'h0;
		rx_out = 8'h00;
	end
	// select fall restarts the count; in phase one select may stay low between bytes
	always @(negedge sel_n_in) begin
		cnt = 0;
		if (!phase_in) miso_out = bit_at(0);
	end
	// a released line must not keep showing its last bit
	always @(posedge sel_n_in) miso_out = ~miso_out;
	// sample edges fill rx, shift edges present the next bit
	always @(sclk_in) begin
		if (!sel_n_in && cnt < 16) begin
			cnt++;
			if ((cnt % 2 == 1) != phase_in) begin
				if (low_first_in) rx_out = {mosi_in, rx_out[7:1]};
				else rx_out = {rx_out[6:0], mosi_in};
			end
			else if (phase_in) miso_out = bit_at((cnt - 1) / 2);
			else if (cnt < 16) miso_out = bit_at(cnt / 2);
		end
	end
endmodule

/* verif/tb_spi_clock_format_and_mode_fault.sv */
`timescale 1ns/1ps
module tb_spi_clock_format_and_mode_fault;
	logic clk_in, arst_n_in;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, rsp;
	logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
	logic sck_o, sck_oe, mo_o, mo_oe, mi_o, mi_oe, ss_o, ss_oe;
	logic tb_sck, tb_mosi, tb_ss_n, md_pha, md_lsb, md_miso;
	logic [7:0] md_tx, md_rx;
	int fail_count, compares;
	// pin levels resolved from the core's enables
	wire sck_w = sck_oe ? sck_o : tb_sck;
	wire mosi_w = mo_oe ? mo_o : tb_mosi;
	wire miso_w = mi_oe ? mi_o : md_miso;
	wire ss_w = ss_oe ? ss_o : tb_ss_n;
	spicf_core dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o),
		.serial_clock_pin_oe_out(sck_oe), .master_data_io_in(mosi_w),
		.master_data_io_out(mo_o), .master_data_io_oe_out(mo_oe), .slave_data_io_in(miso_w),
		.slave_data_io_out(mi_o), .slave_data_io_oe_out(mi_oe), .select_n_in(ss_w),
		.select_n_out(ss_o), .select_n_oe_out(ss_oe), .irq_out(irq));
	spicf_far_model far_u (.sclk_in(sck_w), .sel_n_in(ss_w), .mosi_in(mosi_w), .phase_in(md_pha),
		.low_first_in(md_lsb), .tx_in(md_tx), .miso_out(md_miso), .rx_out(md_rx));
	// 250 MHz bus clock
	initial begin
		clk_in = 1'h0;
		forever #2 clk_in = ~clk_in;
	end
	task automatic close_out();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// a spent wait bound counts as a mismatch and ends the run
	task automatic guard(input int n);
		if (n >= 200) begin
			fail_count++;
			close_out();
		end
	endtask
	// ready is judged at the falling edge, so the next rising edge is the handshake
	task automatic hold(ref logic s);
		int n;
		n = 0;
		@(negedge clk_in);
		while (s !== 1'h1 && n < 200) begin
			@(negedge clk_in);
			n++;
		end
		guard(n);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid, bready} <= 3'h7;
		hold(awready);
		@(posedge clk_in);
		{awvalid, wvalid} <= 2'h0;
		hold(bvalid);
		rsp = bresp;
		@(posedge clk_in);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_in);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		hold(arready);
		@(posedge clk_in);
		arvalid <= 1'h0;
		hold(rvalid);
		d = rdata;
		rsp = rresp;
		@(posedge clk_in);
		rready <= 1'h0;
	endtask
	task automatic reset_regs();
		logic [31:0] d;
		rd(spicf_pkg::ADDR_BAUD, d);
		chk("baud reset", d, 32'(spicf_pkg::BAUD_RESET));
		wr(spicf_pkg::ADDR_STATUS, 32'h0);
		chk("status write", 32'(rsp), 32'(spicf_pkg::RESP_SLVERR));
		rd(5'h14, d);
		chk("unmapped", 32'(rsp), 32'(spicf_pkg::RESP_SLVERR));
	endtask
	// one master byte per clock format, low bit first in formats one and two
	task automatic master_mode(input logic [1:0] m);
		logic [31:0] d;
		int n;
		md_pha = m[0];
		md_lsb = ^m;
		md_tx = 8'h96 + 8'(m);
		wr(spicf_pkg::ADDR_CTRL2, 32'h10);
		wr(spicf_pkg::ADDR_CTRL1, {24'h0, 4'h5, m, 1'h1, ^m});
		chk("idle clock", 32'(sck_w), 32'(m[1]));
		wr(spicf_pkg::ADDR_DATA, {24'h0, 8'h3C ^ 8'(m)});
		n = 0;
		while (ss_w !== 1'h0 && n < 200) begin
			@(posedge clk_in);
			n++;
		end
		guard(n);
		chk("lead clock", 32'(sck_w), 32'(m[1]));
		d = 32'h0;
		n = 0;
		while (d[7] !== 1'h1 && n < 200) begin
			rd(spicf_pkg::ADDR_STATUS, d);
			n++;
		end
		guard(n);
		chk("select after", 32'(ss_w), 32'h1);
		rd(spicf_pkg::ADDR_DATA, d);
		chk("master rx", d, {24'h0, md_tx});
		chk("far rx", 32'(md_rx), 32'(8'h3C ^ 8'(m)));
		chk("rest clock", 32'(sck_w), 32'(m[1]));
	endtask
	// another master pulls select low while fault detection watches it
	task automatic fault_case();
		logic [31:0] d;
		wr(spicf_pkg::ADDR_CTRL1, 32'hD0);
		tb_ss_n <= 1'h0;
		repeat (6) @(posedge clk_in);
		rd(spicf_pkg::ADDR_CTRL1, d);
		chk("master cleared", 32'(d[4]), 32'h0);
		chk("drivers off", 32'({sck_oe, mo_oe, mi_oe}), 32'h0);
		chk("fault irq", 32'(irq), 32'h1);
		tb_ss_n <= 1'h1;
		wr(spicf_pkg::ADDR_CTRL1, 32'hC0);
		rd(spicf_pkg::ADDR_STATUS, d);
		chk("fault kept", 32'(d[4]), 32'h1);
		// receive mask stays on, so a low irq shows that the flag really cleared
		wr(spicf_pkg::ADDR_CTRL1, 32'hC0);
		rd(spicf_pkg::ADDR_STATUS, d);
		chk("fault cleared", 32'(d[4]), 32'h0);
		chk("irq low", 32'(irq), 32'h0);
	endtask
	// bench acts as master with a 64 ns link clock, format zero, high bit first
	task automatic slave_case();
		logic [31:0] d;
		logic [7:0] got;
		got = 8'h00;
		wr(spicf_pkg::ADDR_DATA, 32'h5A);
		tb_ss_n <= 1'h0;
		repeat (16) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			tb_mosi <= 1'(8'hA3 >> (7 - i));
			repeat (8) @(posedge clk_in);
			got = {got[6:0], miso_w};
			tb_sck <= 1'h1;
			repeat (8) @(posedge clk_in);
			tb_sck <= 1'h0;
		end
		repeat (16) @(posedge clk_in);
		tb_ss_n <= 1'h1;
		tb_mosi <= ~tb_mosi;
		chk("slave tx", 32'(got), 32'h5A);
		rd(spicf_pkg::ADDR_STATUS, d);
		chk("slave full", 32'(d[7]), 32'h1);
		rd(spicf_pkg::ADDR_DATA, d);
		chk("slave rx", d, 32'hA3);
	endtask
	// single-pin master: only its own data pin drives; a fault moves data to the other pin
	task automatic single_case();
		wr(spicf_pkg::ADDR_CTRL2, 32'h19);
		wr(spicf_pkg::ADDR_CTRL1, 32'h50);
		chk("single master pins", 32'({mo_oe, mi_oe}), 32'h2);
		chk("single clock", 32'(sck_oe), 32'h1);
		tb_ss_n <= 1'h0;
		repeat (6) @(posedge clk_in);
		chk("single fault pins", 32'({sck_oe, mo_oe, mi_oe}), 32'h1);
		tb_ss_n <= 1'h1;
	endtask
	// main sequence
	initial begin
		fail_count = 0;
		compares = 0;
		arst_n_in = 1'h0;
		{awvalid, wvalid, bready, arvalid, rready, tb_sck, tb_mosi} = 7'h0;
		{awaddr, araddr, wdata} = 42'h0;
		{tb_ss_n, md_pha, md_lsb, md_tx} = 11'h400;
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1'h1;
		reset_regs();
		for (int m = 0; m < 4; m++) master_mode(2'(m));
		fault_case();
		slave_case();
		single_case();
		close_out();
	end
endmodule
